// ### hw/msrc_regs.svh
// Register indices, field positions, reset values and timing counts of the standby block.
`ifndef MSRC_REGS_SVH
`define MSRC_REGS_SVH

// Register indices; the Avalon byte address of a register is four times its index.
`define MSRC_IDX_W            16
`define MSRC_ADDR_W           18
`define MSRC_IDX_REF_CTRL     16'hFFA4
`define MSRC_IDX_STATUS       16'hFFA6
`define MSRC_IDX_STANDBY      16'hFFFB

// Module standby register fields; a 1 lets the module run.
`define MSRC_SB_ADDR_BREAK    7
`define MSRC_SB_PULSE_UNIT    6
`define MSRC_SB_I2C_IF        5
`define MSRC_SB_PWM_B         4
`define MSRC_SB_EVENT_CNT     3
`define MSRC_SB_WATCHDOG      2
`define MSRC_SB_PWM_A         1
`define MSRC_SB_LCD           0
`define MSRC_SB_RESET         8'h80

// Reference control register fields.
`define MSRC_REF_RUN          7
`define MSRC_REF_RSVD_HI      6
`define MSRC_REF_RSVD_LO      3
`define MSRC_REF_RSVD_VAL     4'hF
`define MSRC_REF_TRIM_HI      2
`define MSRC_REF_TRIM_LO      0
`define MSRC_REF_RUN_RESET    1'b1
`define MSRC_REF_TRIM_RESET   3'h0

// Status register fields.
`define MSRC_ST_WD_RUN        0
`define MSRC_ST_REF_SETTLED   1
`define MSRC_ST_WD_ON         2

// Reference settling time, rounded up to whole clock cycles.
`define MSRC_CLK_PERIOD_NS    20
`define MSRC_SETTLE_TIME_NS   70000
`define MSRC_SETTLE_CYCLES    ((`MSRC_SETTLE_TIME_NS + `MSRC_CLK_PERIOD_NS - 1) / `MSRC_CLK_PERIOD_NS)
`define MSRC_SETTLE_CNT_W     12

`endif

// ### hw/msrc_pkg.sv
// Types shared by the standby and reference control block.
`default_nettype none
`include "msrc_regs.svh"
package msrc_pkg;
  typedef logic [`MSRC_IDX_W-1:0] msrc_idx_t;
  typedef logic [7:0]             msrc_byte_t;
  typedef logic [2:0]             msrc_trim_t;

  typedef struct packed {
    logic        wait_r;
    logic [31:0] rdata_r;
  } msrc_slv_s;

  typedef struct packed {
    logic [`MSRC_SETTLE_CNT_W-1:0] count_r;
    logic                          settled_r;
  } msrc_settle_s;

  typedef struct packed {
    msrc_byte_t standby_r;
    logic       ref_run_r;
    msrc_trim_t trim_r;
    logic       wd_run_r;
    logic       lcd_halt_r;
  } msrc_top_s;
endpackage
`default_nettype wire

// ### hw/msrc_reg_if.sv
// Register access strobes between the bus slave and the register core.
`timescale 1ns/1ps
`default_nettype none
interface msrc_reg_if;
  import msrc_pkg::*;
  logic       wr_stb;
  logic       rd_stb;
  msrc_idx_t  index;
  msrc_byte_t wdata;
  msrc_byte_t rdata;
  modport bus  (output wr_stb, output rd_stb, output index, output wdata, input rdata);
  modport core (input wr_stb, input rd_stb, input index, input wdata, output rdata);
endinterface
`default_nettype wire

// ### hw/msrc_avmm_slave.sv
// Avalon-MM slave that answers every access one cycle after it is seen.
`timescale 1ns/1ps
`default_nettype none
`include "msrc_regs.svh"
module msrc_avmm_slave (
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  input  wire logic [`MSRC_ADDR_W-1:0]  avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  msrc_reg_if.bus                       rif
);
  import msrc_pkg::*;

  msrc_slv_s s;
  msrc_slv_s s_nxt;
  logic      accept;
  logic      aligned;

  always_comb begin
    aligned    = (avs_address[1:0] == 2'h0);
    accept     = (avs_read | avs_write) & s.wait_r;
    rif.index  = avs_address[`MSRC_ADDR_W-1:2];
    rif.wdata  = avs_writedata[7:0];
    rif.wr_stb = accept & avs_write & avs_byteenable[0] & aligned;
    rif.rd_stb = accept & avs_read & aligned;
    s_nxt      = s;
    // Waitrequest drops for exactly one cycle per access, then rises again.
    if (accept) begin
      s_nxt.wait_r  = 1'b0;
      s_nxt.rdata_r = rif.rd_stb ? {24'h000000, rif.rdata} : 32'h00000000;
    end else begin
      s_nxt.wait_r  = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{wait_r: 1'b1, rdata_r: 32'h00000000};
    end else begin
      s <= s_nxt;
    end
  end

  assign avs_readdata    = s.rdata_r;
  assign avs_waitrequest = s.wait_r;

  chk_wait_answer: assert property (@(posedge clock) disable iff (!rst_b)
    (avs_read | avs_write) && s.wait_r |=> !s.wait_r)
    else $error("access not answered in one cycle");
  chk_wait_single: assert property (@(posedge clock) disable iff (!rst_b)
    !s.wait_r |=> s.wait_r)
    else $error("waitrequest low for more than one cycle");
endmodule
`default_nettype wire

// ### hw/msrc_settle.sv
// Counts the reference settling time after the run request rises.
`timescale 1ns/1ps
`default_nettype none
`include "msrc_regs.svh"
module msrc_settle (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic run,
  output logic      settled
);
  import msrc_pkg::*;

  localparam logic [`MSRC_SETTLE_CNT_W-1:0] LAST = `MSRC_SETTLE_CNT_W'(`MSRC_SETTLE_CYCLES - 1);

  msrc_settle_s s;
  msrc_settle_s s_nxt;

  always_comb begin
    s_nxt = s;
    if (!run) begin
      s_nxt.count_r   = '0;
      s_nxt.settled_r = 1'b0;
    end else if (!s.settled_r) begin
      // Settled is only reported once the full settling time has run.
      if (s.count_r == LAST) begin
        s_nxt.settled_r = 1'b1;
      end else begin
        s_nxt.count_r = s.count_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{count_r: '0, settled_r: 1'b0};
    end else begin
      s <= s_nxt;
    end
  end

  assign settled = s.settled_r;

  chk_settle_stop: assert property (@(posedge clock) disable iff (!rst_b)
    !run |=> !settled)
    else $error("settled while reference stopped");
  chk_settle_time: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(settled) |-> s.count_r == LAST)
    else $error("settled before the settling count ran out");
endmodule
`default_nettype wire

// ### hw/msrc_top.sv
// Module standby and band-gap reference control registers behind an Avalon-MM slave.
`timescale 1ns/1ps
`default_nettype none
`include "msrc_regs.svh"
module msrc_top (
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  input  wire logic [`MSRC_ADDR_W-1:0]  avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  input  wire logic                     watchdog_on,
  output logic                          addr_break_run,
  output logic                          pulse_unit_run,
  output logic                          i2c_if_run,
  output logic                          pwm_b_run,
  output logic                          event_counter_run,
  output logic                          watchdog_run,
  output logic                          pwm_a_run,
  output logic                          lcd_run,
  output logic                          reference_run,
  output msrc_pkg::msrc_trim_t          reference_trim,
  output logic                          lcd_supply_halt
);
  import msrc_pkg::*;

  msrc_reg_if rif ();

  msrc_top_s s;
  msrc_top_s s_nxt;
  logic      sb_wr;
  logic      ref_wr;
  logic      settled;

  msrc_avmm_slave u_slave (
    .clock           (clock),
    .rst_b           (rst_b),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .rif             (rif)
  );

  // Status bit only; software may poll it instead of timing the wait itself.
  msrc_settle u_settle (
    .clock   (clock),
    .rst_b   (rst_b),
    .run     (s.ref_run_r),
    .settled (settled)
  );

  always_comb begin
    sb_wr  = rif.wr_stb & (rif.index == `MSRC_IDX_STANDBY);
    ref_wr = rif.wr_stb & (rif.index == `MSRC_IDX_REF_CTRL);
    s_nxt  = s;
    if (sb_wr) begin
      s_nxt.standby_r = rif.wdata;
    end
    if (ref_wr) begin
      s_nxt.ref_run_r = rif.wdata[`MSRC_REF_RUN];
      s_nxt.trim_r    = rif.wdata[`MSRC_REF_TRIM_HI:`MSRC_REF_TRIM_LO];
    end
    // While watchdog_on is set the watchdog ignores its standby bit; no register write clears watchdog_on.
    s_nxt.wd_run_r   = s_nxt.standby_r[`MSRC_SB_WATCHDOG] | watchdog_on;
    s_nxt.lcd_halt_r = ~s_nxt.ref_run_r;
  end

  always_comb begin
    rif.rdata = 8'h00;
    unique case (rif.index)
      `MSRC_IDX_STANDBY: begin
        rif.rdata = s.standby_r;
      end
      `MSRC_IDX_REF_CTRL: begin
        rif.rdata = {s.ref_run_r, `MSRC_REF_RSVD_VAL, s.trim_r};
      end
      `MSRC_IDX_STATUS: begin
        rif.rdata[`MSRC_ST_WD_RUN]      = s.wd_run_r;
        rif.rdata[`MSRC_ST_REF_SETTLED] = settled;
        rif.rdata[`MSRC_ST_WD_ON]       = watchdog_on;
      end
      default: begin
        rif.rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{standby_r:  `MSRC_SB_RESET,
             ref_run_r:  `MSRC_REF_RUN_RESET,
             trim_r:     `MSRC_REF_TRIM_RESET,
             wd_run_r:   1'b0,
             lcd_halt_r: ~`MSRC_REF_RUN_RESET};
    end else begin
      s <= s_nxt;
    end
  end

  // Each module's run output is its stored standby bit, except watchdog_run, which is that bit ORed with watchdog_on.
  assign addr_break_run    = s.standby_r[`MSRC_SB_ADDR_BREAK];
  assign pulse_unit_run    = s.standby_r[`MSRC_SB_PULSE_UNIT];
  assign i2c_if_run        = s.standby_r[`MSRC_SB_I2C_IF];
  assign pwm_b_run         = s.standby_r[`MSRC_SB_PWM_B];
  assign event_counter_run = s.standby_r[`MSRC_SB_EVENT_CNT];
  assign watchdog_run      = s.wd_run_r;
  assign pwm_a_run         = s.standby_r[`MSRC_SB_PWM_A];
  assign lcd_run           = s.standby_r[`MSRC_SB_LCD];
  assign reference_run     = s.ref_run_r;
  assign reference_trim    = s.trim_r;
  assign lcd_supply_halt   = s.lcd_halt_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence seq_sb_write;
    sb_wr;
  endsequence

  sequence seq_wd_release;
    $fell(watchdog_on) ##0 !s.standby_r[`MSRC_SB_WATCHDOG] ##0 !sb_wr;
  endsequence

  chk_standby_write: assert property (seq_sb_write |=> s.standby_r == $past(rif.wdata))
    else $error("standby register did not take the written byte");
  chk_standby_hold: assert property (!sb_wr |=> $stable(s.standby_r))
    else $error("standby register changed without a write");
  chk_brk_run_map: assert property (seq_sb_write |=>
    addr_break_run == $past(rif.wdata[`MSRC_SB_ADDR_BREAK]))
    else $error("address break run does not follow bit 7");
  chk_lcd_run_map: assert property (seq_sb_write |=>
    lcd_run == $past(rif.wdata[`MSRC_SB_LCD]) && pwm_a_run == $past(rif.wdata[`MSRC_SB_PWM_A]))
    else $error("LCD or first PWM run does not follow its bit");
  chk_wd_defer: assert property (watchdog_on |=> watchdog_run)
    else $error("watchdog stopped while watchdog_on is set");
  chk_wd_release: assert property (seq_wd_release |=> !watchdog_run)
    else $error("watchdog did not enter standby after watchdog_on fell");
  // The bench's read right after an accepted write is accepted three edges later; the slave could accept one two edges later.
  chk_wd_readback: assert property (seq_sb_write ##3
    (rif.rd_stb && rif.index == `MSRC_IDX_STANDBY)
    |-> rif.rdata[`MSRC_SB_WATCHDOG] == $past(rif.wdata[`MSRC_SB_WATCHDOG], 3))
    else $error("watchdog standby bit does not read back as written");
  chk_ref_write: assert property (ref_wr |=> reference_run == $past(rif.wdata[`MSRC_REF_RUN])
    && reference_trim == $past(rif.wdata[`MSRC_REF_TRIM_HI:`MSRC_REF_TRIM_LO]))
    else $error("reference control did not take the written byte");
  chk_ref_rsvd: assert property (rif.index == `MSRC_IDX_REF_CTRL |->
    rif.rdata[`MSRC_REF_RSVD_HI:`MSRC_REF_RSVD_LO] == `MSRC_REF_RSVD_VAL)
    else $error("reserved reference bits do not read as ones");
  chk_trim_hold: assert property (!ref_wr |=> $stable(reference_trim))
    else $error("trim code changed without a write");
  chk_lcd_halt: assert property ($fell(reference_run) |->
    lcd_supply_halt ##1 (lcd_supply_halt || $rose(reference_run)))
    else $error("LCD supply not halted with the reference stopped");
  chk_halt_pair: assert property (lcd_supply_halt != reference_run)
    else $error("LCD supply halt disagrees with reference run");
endmodule
`default_nettype wire

// ### tb/msrc_top_bench.sv
// Self-checking bench for the module standby and reference control block.
`timescale 1ns/1ps
`default_nettype none
`include "msrc_regs.svh"
module msrc_top_bench;
  import msrc_pkg::*;
  localparam logic [17:0] A_SB  = {`MSRC_IDX_STANDBY, 2'b00};
  localparam logic [17:0] A_REF = {`MSRC_IDX_REF_CTRL, 2'b00};
  localparam logic [17:0] A_ST  = {`MSRC_IDX_STATUS, 2'b00};
  localparam int          NROW  = 13;
  typedef struct {
    logic [17:0] a;
    logic [7:0]  d;
    logic [7:0]  rd;
    logic [7:0]  o;
  } msrc_row_s;
  logic        clock;
  logic        rst_b;
  logic [17:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        watchdog_on;
  logic        addr_break_run;
  logic        pulse_unit_run;
  logic        i2c_if_run;
  logic        pwm_b_run;
  logic        event_counter_run;
  logic        watchdog_run;
  logic        pwm_a_run;
  logic        lcd_run;
  logic        reference_run;
  msrc_trim_t  reference_trim;
  logic        lcd_supply_halt;
  logic [7:0]  runs_w;
  logic [7:0]  refo_w;
  logic [31:0] q;
  int          n_fail;
  int          comparisons;
  msrc_row_s   rows [NROW] = '{
    '{A_SB, 8'hFF, 8'hFF, 8'hFF}, '{A_SB, 8'h00, 8'h00, 8'h00},
    '{A_SB, 8'h55, 8'h55, 8'h55}, '{A_SB, 8'hAA, 8'hAA, 8'hAA},
    '{A_REF, 8'h00, 8'h78, 8'h40}, '{A_REF, 8'h01, 8'h79, 8'h41},
    '{A_REF, 8'h82, 8'hFA, 8'h82}, '{A_REF, 8'h03, 8'h7B, 8'h43},
    '{A_REF, 8'h84, 8'hFC, 8'h84}, '{A_REF, 8'h05, 8'h7D, 8'h45},
    '{A_REF, 8'h86, 8'hFE, 8'h86}, '{A_REF, 8'h07, 8'h7F, 8'h47},
    '{A_REF, 8'hFF, 8'hFF, 8'h87}};

  assign runs_w = {addr_break_run, pulse_unit_run, i2c_if_run, pwm_b_run,
                   event_counter_run, watchdog_run, pwm_a_run, lcd_run};
  assign refo_w = {reference_run, lcd_supply_halt, 3'h0, reference_trim};

  msrc_top dut (
    .clock             (clock),
    .rst_b             (rst_b),
    .avs_address       (avs_address),
    .avs_read          (avs_read),
    .avs_write         (avs_write),
    .avs_writedata     (avs_writedata),
    .avs_byteenable    (avs_byteenable),
    .avs_readdata      (avs_readdata),
    .avs_waitrequest   (avs_waitrequest),
    .watchdog_on       (watchdog_on),
    .addr_break_run    (addr_break_run),
    .pulse_unit_run    (pulse_unit_run),
    .i2c_if_run        (i2c_if_run),
    .pwm_b_run         (pwm_b_run),
    .event_counter_run (event_counter_run),
    .watchdog_run      (watchdog_run),
    .pwm_a_run         (pwm_a_run),
    .lcd_run           (lcd_run),
    .reference_run     (reference_run),
    .reference_trim    (reference_trim),
    .lcd_supply_halt   (lcd_supply_halt)
  );

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One access; the request is held until the edge where waitrequest is seen low.
  task automatic bus(input logic wr, input logic [17:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    int k;
    rd = 32'h0;
    @(posedge clock);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= ~wr;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      n_fail++;
      $display("[FAIL] waitrequest expected 0 seen %b", avs_waitrequest);
      stop_test();
    end else begin
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask

  initial begin
    rst_b = 1'b0;
    avs_address = 18'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    watchdog_on = 1'b0;
    n_fail = 0;
    comparisons = 0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    chk("run outputs", {24'h0, runs_w}, 32'h80);
    chk("reference outputs", {24'h0, refo_w}, 32'h80);
    chk("waitrequest idle", {31'h0, avs_waitrequest}, 32'h1);
    bus(1'b0, A_SB, 8'h00, 4'h1, q);
    chk("standby reset", q, 32'h80);
    bus(1'b0, A_REF, 8'h00, 4'h1, q);
    chk("reference reset", q, 32'hF8);
    $display("test reset done");

    for (int i = 0; i < NROW; i++) begin
      bus(1'b1, rows[i].a, rows[i].d, 4'h1, q);
      bus(1'b0, rows[i].a, 8'h00, 4'h1, q);
      chk("readback", q, {24'h0, rows[i].rd});
      chk("outputs", {24'h0, (rows[i].a == A_SB) ? runs_w : refo_w},
          {24'h0, rows[i].o});
    end
    $display("test table done");

    watchdog_on <= 1'b1;
    bus(1'b1, A_SB, 8'h04, 4'h1, q);
    bus(1'b1, A_SB, 8'h00, 4'h1, q);
    bus(1'b0, A_SB, 8'h00, 4'h1, q);
    chk("standby with watchdog on", q, 32'h00);
    chk("watchdog kept running", {31'h0, watchdog_run}, 32'h1);
    bus(1'b0, A_ST, 8'h00, 4'h1, q);
    chk("status watchdog", {30'h0, q[`MSRC_ST_WD_ON], q[`MSRC_ST_WD_RUN]}, 32'h3);
    watchdog_on <= 1'b0;
    repeat (2) @(posedge clock);
    chk("watchdog stopped", {31'h0, watchdog_run}, 32'h0);
    $display("test watchdog done");

    bus(1'b0, 18'h0, 8'h00, 4'h1, q);
    chk("unmapped read", q, 32'h0);
    bus(1'b0, A_SB + 18'h1, 8'h00, 4'h1, q);
    chk("misaligned read", q, 32'h0);
    bus(1'b1, 18'h0, 8'hFF, 4'h1, q);
    bus(1'b1, A_SB + 18'h1, 8'hFF, 4'h1, q);
    bus(1'b1, A_SB, 8'hFF, 4'h0, q);
    bus(1'b0, A_SB, 8'h00, 4'h1, q);
    chk("standby untouched", q, 32'h00);
    chk("runs untouched", {24'h0, runs_w}, 32'h00);
    $display("test ignored writes done");

    bus(1'b1, A_REF, 8'h00, 4'h1, q);
    chk("supply halted", {31'h0, lcd_supply_halt}, 32'h1);
    bus(1'b1, A_REF, 8'h80, 4'h1, q);
    bus(1'b0, A_ST, 8'h00, 4'h1, q);
    chk("not yet settled", {31'h0, q[`MSRC_ST_REF_SETTLED]}, 32'h0);
    // The next read is accepted on the same edge that sets settled, so it still reads settled clear.
    repeat (`MSRC_SETTLE_CYCLES - 6) @(posedge clock);
    bus(1'b0, A_ST, 8'h00, 4'h1, q);
    chk("settle end point", {31'h0, q[`MSRC_ST_REF_SETTLED]}, 32'h0);
    bus(1'b0, A_ST, 8'h00, 4'h1, q);
    chk("settled", {31'h0, q[`MSRC_ST_REF_SETTLED]}, 32'h1);
    $display("test settle done");

    bus(1'b1, A_SB, 8'h7F, 4'h1, q);
    bus(1'b1, A_REF, 8'h03, 4'h1, q);
    rst_b <= 1'b0;
    @(posedge clock);
    chk("runs after reset", {24'h0, runs_w}, 32'h80);
    chk("reference after reset", {24'h0, refo_w}, 32'h80);
    rst_b <= 1'b1;
    bus(1'b0, A_REF, 8'h00, 4'h1, q);
    chk("reference read after reset", q, 32'hF8);
    $display("test second reset done");
    stop_test();
  end
endmodule
`default_nettype wire
